// ### verilog/pidsc_cfg.svh
// offsets, codes, reset values and timing counts of the pid speed regulator
`ifndef PIDSC_CFG_SVH
`define PIDSC_CFG_SVH
`define PIDSC_ACT_OFS 8'h00
`define PIDSC_SETP_OFS 8'h04
`define PIDSC_UPL_OFS 8'h08
`define PIDSC_LOWL_OFS 8'h0C
`define PIDSC_SPRNG_OFS 8'h10
`define PIDSC_MVRNG_OFS 8'h14
`define PIDSC_GAIN_OFS 8'h18
`define PIDSC_BASE_OFS 8'h1C
`define PIDSC_STAT_OFS 8'h20
`define PIDSC_PV_OFS 8'h24
`define PIDSC_FREQ_OFS 8'h28
`define PIDSC_INF_OFS 8'h40
`define PIDSC_OUTF_OFS 8'h60
`define PIDSC_CODE_OFF 8'h00
`define PIDSC_CODE_REV 8'h14
`define PIDSC_CODE_FWD 8'h15
`define PIDSC_CODE_SEL 8'h0E
`define PIDSC_CODE_UP 8'h0F
`define PIDSC_CODE_LOW 8'h0E
`define PIDSC_CODE_NEG 8'h64
`define PIDSC_UNUSED 14'h270F
`define PIDSC_PCT_FULL 11'h3E8
`define PIDSC_K_10V 17'h03E84
`define PIDSC_K_5V 17'h07D08
`define PIDSC_K_MA 17'h04E25
`define PIDSC_MA4 12'h333
`define PIDSC_SPRNG_RST 8'h01
`define PIDSC_MVRNG_RST 2'h0
`define PIDSC_GAIN_RST 27'h3000110
`define PIDSC_BASE_RST 16'h0000
`define PIDSC_FMAX 16'h9C40
`define PIDSC_GAIN_SHIFT 4
`define PIDSC_CLK_HZ 25000000
`define PIDSC_SAMPLE_US 1000
`define PIDSC_SAMPLE_CYC (`PIDSC_SAMPLE_US * (`PIDSC_CLK_HZ / 1000000))
`endif

// ### verilog/pidsc_pkg.sv
// types shared by the pid speed regulator modules
package pidsc_pkg;
    typedef enum logic [2:0] {
        PIDSC_PLAIN = 3'b001,
        PIDSC_REV = 3'b010,
        PIDSC_FWD = 3'b100
    } pidsc_mode_t;
    typedef enum logic [1:0] {
        PIDSC_RNG_10V = 2'h0,
        PIDSC_RNG_5V = 2'h1,
        PIDSC_RNG_MA = 2'h2
    } pidsc_rng_t;
    typedef logic [10:0] pidsc_pct_t;
endpackage

// ### verilog/pidsc_scale.sv
// scales a 12-bit analog sample into 0.1 percent units, 0 to 1000
`timescale 1ns/10ps
`include "pidsc_cfg.svh"
module pidsc_scale import pidsc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [11:0] adc,
    input wire pidsc_rng_t rng,
    output pidsc_pct_t pct
);
    logic [11:0] span;
    logic [16:0] gain;
    logic [28:0] prod;

    // reciprocal multiply avoids a divider; full code is 10 V or 20 mA
    always_comb begin
        case (rng)
            PIDSC_RNG_MA: begin
                span = (adc >= `PIDSC_MA4) ? adc - `PIDSC_MA4 : 12'h000;
                gain = `PIDSC_K_MA;
            end
            PIDSC_RNG_5V: begin
                span = adc;
                gain = `PIDSC_K_5V;
            end
            default: begin
                span = adc;
                gain = `PIDSC_K_10V;
            end
        endcase
        prod = 29'(span * gain);
    end

    // clamp at full scale, over-range inputs read 100 percent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pct <= 11'h000;
        end else if (prod[28:16] > 13'(`PIDSC_PCT_FULL)) begin
            pct <= `PIDSC_PCT_FULL;
        end else begin
            pct <= prod[26:16];
        end
    end
endmodule // pidsc_scale

// ### verilog/pidsc_loop.sv
// pid arithmetic: deviation, three terms, corrected output frequency
`timescale 1ns/10ps
`include "pidsc_cfg.svh"
module pidsc_loop import pidsc_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire pidsc_mode_t mode,
    input wire pidsc_pct_t sp,
    input wire pidsc_pct_t pv,
    input wire logic [7:0] kp,
    input wire logic [7:0] ki,
    input wire logic [7:0] kd,
    input wire logic [2:0] term_en,
    input wire logic [15:0] base_freq,
    output logic [15:0] freq,
    output logic signed [24:0] mv
);
    logic signed [12:0] err;
    logic signed [12:0] err_prev;
    logic signed [21:0] p_term;
    logic signed [21:0] i_step;
    logic signed [22:0] d_term;
    logic signed [23:0] integ;
    logic signed [24:0] next_integ;
    logic signed [24:0] next_mv;
    logic signed [25:0] fsum;

    // deviation is set point minus measured, sign flipped in forward action
    always_comb begin
        err = $signed({2'b00, sp}) - $signed({2'b00, pv});
        if (mode == PIDSC_FWD) begin
            err = -err;
        end
        p_term = $signed({1'b0, kp}) * err;
        i_step = $signed({1'b0, ki}) * err;
        d_term = $signed({1'b0, kd}) * (14'(err) - 14'(err_prev));
        next_integ = 25'(integ) + 25'(i_step);
        // disabled terms drop out of the sum
        next_mv = (term_en[0] ? 25'(p_term) : 25'sh0) + (term_en[1] ? 25'(integ) : 25'sh0)
            + (term_en[2] ? 25'(d_term) : 25'sh0);
        fsum = $signed({10'h000, base_freq}) + 26'(next_mv >>> `PIDSC_GAIN_SHIFT);
    end

    // integrator saturates instead of wrapping; cleared while idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            integ <= 24'sh0;
            err_prev <= 13'sh0;
        end else if (mode == PIDSC_PLAIN) begin
            integ <= 24'sh0;
            err_prev <= 13'sh0;
        end else if (tick) begin
            err_prev <= err;
            if (!term_en[1]) begin
                integ <= 24'sh0;
            end else if (next_integ > 25'sh7FFFFF) begin
                integ <= 24'sh7FFFFF;
            end else if (next_integ < -25'sh800000) begin
                integ <= -24'sh800000;
            end else begin
                integ <= next_integ[23:0];
            end
        end
    end

    // output frequency updated once per sample, clamped to range
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq <= 16'h0000;
            mv <= 25'sh0;
        end else if (tick) begin
            mv <= next_mv;
            if (fsum < 26'sh0) begin
                freq <= 16'h0000;
            end else if (fsum > 26'($unsigned(`PIDSC_FMAX))) begin
                freq <= `PIDSC_FMAX;
            end else begin
                freq <= fsum[15:0];
            end
        end
    end
endmodule // pidsc_loop

// ### verilog/pidsc_top.sv
// pid process speed regulator with ahb-lite register access
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`include "pidsc_cfg.svh"
// Function
// - The loop runs only when the action selection holds 20 or 21.
// - Action selection 0 or an inactive select input gives plain frequency with no correction.
// - Code 14 in an input terminal function maps that terminal to the select input, which must be on.
// - With no terminal mapped to the select input, the action selection alone enables regulation.
// - Reverse action takes set point minus measured and raises frequency for positive deviation.
// - Forward action raises frequency for negative deviation and lowers it for positive.
// - The manipulated variable is the sum of the enabled proportional, integral and derivative terms.
// - Set point value 9999 takes the set point terminal, 0 to 100 percent uses the stored value.
// - Set point terminal is 0 to 5V for range 1 or 11, 0 to 10V for 0 or 10, full input 100 percent.
// - Measured terminal range 0 is 4 to 20mA, 1 is 0 to 5V, 2 is 0 to 10V, scaled to 0 to 100 percent.
// - While regulating with upper limit not 9999, codes 15 or 115 show measured value above the limit.
// - While regulating with lower limit not 9999, codes 14 or 114 show the measured value below the limit.
// - An output function code of 100 or more drives its flag inverted, below 100 true.
module pidsc_top import pidsc_pkg::*; #(
    parameter int N_IN = 5,
    parameter int N_OUT = 3,
    parameter int SAMPLE_CYC = `PIDSC_SAMPLE_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [N_IN-1:0] in_term,
    input wire logic [11:0] setpoint_adc,
    input wire logic [11:0] measured_adc,
    output logic [N_OUT-1:0] out_term,
    output logic [15:0] freq_out,
    output logic upper_limit_flag,
    output logic lower_limit_flag,
    output logic pid_active
);
    logic [N_IN-1:0] term_s1;
    logic [N_IN-1:0] term_s2;
    logic [11:0] sp_s1;
    logic [11:0] sp_s2;
    logic [11:0] pv_s1;
    logic [11:0] pv_s2;
    logic wr_pend;
    logic rd_wait;
    logic [7:0] bus_addr;
    logic take;
    logic [31:0] next_rdata;
    logic [7:0] pid_action_selection;
    logic [13:0] setpoint_value_param;
    logic [13:0] upper_limit_param;
    logic [13:0] lower_limit_param;
    logic [7:0] setpoint_terminal_range;
    logic [1:0] measured_terminal_range;
    logic [26:0] gain_reg;
    logic [15:0] base_freq;
    logic [7:0] input_terminal_function_params [N_IN];
    logic [7:0] output_terminal_function_params [N_OUT];
    logic [N_IN-1:0] sel_map;
    logic sel_assigned;
    logic pid_select_input;
    logic code_ok;
    logic active;
    pidsc_mode_t mode;
    pidsc_rng_t sp_rng;
    pidsc_rng_t pv_rng;
    pidsc_pct_t sp_term;
    pidsc_pct_t pv_pct;
    pidsc_pct_t sp_eff;
    logic [15:0] loop_freq;
    logic signed [24:0] loop_mv;
    logic [$clog2(SAMPLE_CYC)-1:0] div_cnt;
    logic tick;

    // pins and converter words come from outside the clock domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            term_s1 <= '0;
            term_s2 <= '0;
            sp_s1 <= 12'h000;
            sp_s2 <= 12'h000;
            pv_s1 <= 12'h000;
            pv_s2 <= 12'h000;
        end else begin
            term_s1 <= in_term;
            term_s2 <= term_s1;
            sp_s1 <= setpoint_adc;
            sp_s2 <= sp_s1;
            pv_s1 <= measured_adc;
            pv_s2 <= pv_s1;
        end
    end

    // bus address phase; reads take one wait state so data is registered
    assign take = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_wait <= 1'b0;
            bus_addr <= 8'h00;
        end else if (take) begin
            wr_pend <= hwrite && (hsize == 3'b010);
            rd_wait <= !hwrite;
            bus_addr <= {haddr[7:2], 2'b00};
        end else begin
            wr_pend <= 1'b0;
            rd_wait <= 1'b0;
        end
    end
    assign hreadyout = !rd_wait;
    assign hresp = 1'b0;

    // loop control registers, written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pid_action_selection <= `PIDSC_CODE_OFF;
            setpoint_value_param <= `PIDSC_UNUSED;
            upper_limit_param <= `PIDSC_UNUSED;
            lower_limit_param <= `PIDSC_UNUSED;
            setpoint_terminal_range <= `PIDSC_SPRNG_RST;
            measured_terminal_range <= `PIDSC_MVRNG_RST;
            gain_reg <= `PIDSC_GAIN_RST;
            base_freq <= `PIDSC_BASE_RST;
        end else if (wr_pend) begin
            case (bus_addr)
                `PIDSC_ACT_OFS: pid_action_selection <= hwdata[7:0];
                `PIDSC_SETP_OFS: setpoint_value_param <= hwdata[13:0];
                `PIDSC_UPL_OFS: upper_limit_param <= hwdata[13:0];
                `PIDSC_LOWL_OFS: lower_limit_param <= hwdata[13:0];
                `PIDSC_SPRNG_OFS: setpoint_terminal_range <= hwdata[7:0];
                `PIDSC_MVRNG_OFS: measured_terminal_range <= hwdata[1:0];
                `PIDSC_GAIN_OFS: gain_reg <= hwdata[26:0];
                `PIDSC_BASE_OFS: base_freq <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // terminal function registers, one word each
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    input_terminal_function_params[gi] <= 8'h00;
                end else if (wr_pend && bus_addr == 8'(`PIDSC_INF_OFS + 4 * gi)) begin
                    input_terminal_function_params[gi] <= hwdata[7:0];
                end
            end
            assign sel_map[gi] = input_terminal_function_params[gi] == `PIDSC_CODE_SEL;
        end
        for (gi = 0; gi < N_OUT; gi++) begin : g_out
            logic [7:0] fn;
            logic neg;
            logic flag;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    output_terminal_function_params[gi] <= 8'h00;
                end else if (wr_pend && bus_addr == 8'(`PIDSC_OUTF_OFS + 4 * gi)) begin
                    output_terminal_function_params[gi] <= hwdata[7:0];
                end
            end
            // the hundreds offset only selects the polarity
            always_comb begin
                neg = output_terminal_function_params[gi] >= `PIDSC_CODE_NEG;
                fn = neg ? output_terminal_function_params[gi] - `PIDSC_CODE_NEG
                    : output_terminal_function_params[gi];
                if (fn == `PIDSC_CODE_UP) begin
                    flag = upper_limit_flag;
                end else if (fn == `PIDSC_CODE_LOW) begin
                    flag = lower_limit_flag;
                end else begin
                    flag = 1'b0;
                end
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    out_term[gi] <= 1'b0;
                end else begin
                    out_term[gi] <= neg ? !flag : flag;
                end
            end
        end
    endgenerate

    // enable decode: select input only matters once some terminal carries it
    always_comb begin
        sel_assigned = |sel_map;
        pid_select_input = |(sel_map & term_s2);
        code_ok = pid_action_selection == `PIDSC_CODE_REV
            || pid_action_selection == `PIDSC_CODE_FWD;
        active = code_ok && (!sel_assigned || pid_select_input);
    end

    // operating mode; plain mode bypasses the correction entirely
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= PIDSC_PLAIN;
        end else begin
            case (mode)
                PIDSC_PLAIN, PIDSC_REV, PIDSC_FWD: begin
                    if (!active) begin
                        mode <= PIDSC_PLAIN;
                    end else if (pid_action_selection == `PIDSC_CODE_FWD) begin
                        mode <= PIDSC_FWD;
                    end else begin
                        mode <= PIDSC_REV;
                    end
                end
                default: mode <= PIDSC_PLAIN;
            endcase
        end
    end
    assign pid_active = mode != PIDSC_PLAIN;

    // input range decode
    always_comb begin
        if (setpoint_terminal_range == 8'h01 || setpoint_terminal_range == 8'h0B) begin
            sp_rng = PIDSC_RNG_5V;
        end else begin
            sp_rng = PIDSC_RNG_10V;
        end
        case (measured_terminal_range)
            2'h1: pv_rng = PIDSC_RNG_5V;
            2'h2: pv_rng = PIDSC_RNG_10V;
            default: pv_rng = PIDSC_RNG_MA;
        endcase
    end

    pidsc_scale u_sp_scale (
        .hclk(hclk),
        .hresetn(hresetn),
        .adc(sp_s2),
        .rng(sp_rng),
        .pct(sp_term)
    );

    pidsc_scale u_pv_scale (
        .hclk(hclk),
        .hresetn(hresetn),
        .adc(pv_s2),
        .rng(pv_rng),
        .pct(pv_pct)
    );

    // stored set point values above full scale are clamped
    always_comb begin
        if (setpoint_value_param == `PIDSC_UNUSED) begin
            sp_eff = sp_term;
        end else if (setpoint_value_param > 14'(`PIDSC_PCT_FULL)) begin
            sp_eff = `PIDSC_PCT_FULL;
        end else begin
            sp_eff = setpoint_value_param[10:0];
        end
    end

    // sample rate divider; one pulse per sample period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else if (div_cnt == $bits(div_cnt)'(SAMPLE_CYC - 1)) begin
            div_cnt <= '0;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    pidsc_loop u_loop (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .mode(mode),
        .sp(sp_eff),
        .pv(pv_pct),
        .kp(gain_reg[7:0]),
        .ki(gain_reg[15:8]),
        .kd(gain_reg[23:16]),
        .term_en(gain_reg[26:24]),
        .base_freq(base_freq),
        .freq(loop_freq),
        .mv(loop_mv)
    );

    // frequency output and limit flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_out <= 16'h0000;
            upper_limit_flag <= 1'b0;
            lower_limit_flag <= 1'b0;
        end else begin
            freq_out <= pid_active ? loop_freq : base_freq;
            upper_limit_flag <= pid_active && upper_limit_param != `PIDSC_UNUSED
                && 14'(pv_pct) > upper_limit_param;
            lower_limit_flag <= pid_active && lower_limit_param != `PIDSC_UNUSED
                && 14'(pv_pct) < lower_limit_param;
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (bus_addr)
            `PIDSC_ACT_OFS: next_rdata[7:0] = pid_action_selection;
            `PIDSC_SETP_OFS: next_rdata[13:0] = setpoint_value_param;
            `PIDSC_UPL_OFS: next_rdata[13:0] = upper_limit_param;
            `PIDSC_LOWL_OFS: next_rdata[13:0] = lower_limit_param;
            `PIDSC_SPRNG_OFS: next_rdata[7:0] = setpoint_terminal_range;
            `PIDSC_MVRNG_OFS: next_rdata[1:0] = measured_terminal_range;
            `PIDSC_GAIN_OFS: next_rdata[26:0] = gain_reg;
            `PIDSC_BASE_OFS: next_rdata[15:0] = base_freq;
            `PIDSC_STAT_OFS: next_rdata[5:0] = {pid_select_input, sel_assigned,
                lower_limit_flag, upper_limit_flag, mode == PIDSC_FWD, pid_active};
            `PIDSC_PV_OFS: next_rdata = {5'h00, sp_eff, 5'h00, pv_pct};
            `PIDSC_FREQ_OFS: next_rdata = {loop_mv[15:0], freq_out};
            default: begin
                for (int i = 0; i < N_IN; i++) begin
                    if (bus_addr == 8'(`PIDSC_INF_OFS + 4 * i)) begin
                        next_rdata[7:0] = input_terminal_function_params[i];
                    end
                end
                for (int i = 0; i < N_OUT; i++) begin
                    if (bus_addr == 8'(`PIDSC_OUTF_OFS + 4 * i)) begin
                        next_rdata[7:0] = output_terminal_function_params[i];
                    end
                end
            end
        endcase
    end

    // read data captured in the wait state, held until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_wait) begin
            hrdata <= next_rdata;
        end
    end
endmodule // pidsc_top

// ### tb/pidsc_top_props.sv
// concurrent checks on the ports of the pid speed regulator top
`timescale 1ns/10ps
module pidsc_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [15:0] freq_out,
    input wire logic upper_limit_flag,
    input wire logic lower_limit_flag,
    input wire logic pid_active
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a transfer is taken only with select, a nonseq or seq type and ready
    logic take;
    assign take = hsel && htrans[1] && hready;
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read not exactly one wait state");
    property p_wr_fast; take && hwrite |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write data phase stalled");
    property p_idle_rdy; !take |=> hreadyout; endproperty
    a_idle_rdy: assert property (p_idle_rdy) else $error("ready low without a read");
    property p_rd_hold; $changed(hrdata) |-> !$past(hreadyout); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a read");
    // flags may lag the mode by the pipeline, so allow a few cycles
    property p_up_reg; !pid_active [*3] |-> !upper_limit_flag; endproperty
    a_up_reg: assert property (p_up_reg) else $error("upper flag while not regulating");
    property p_low_reg; !pid_active [*3] |-> !lower_limit_flag; endproperty
    a_low_reg: assert property (p_low_reg) else $error("lower flag while not regulating");
    property p_fmax; $past(pid_active) |-> freq_out <= 16'h9C40; endproperty
    a_fmax: assert property (p_fmax) else $error("frequency above its ceiling");
endmodule // pidsc_props
bind pidsc_top pidsc_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .freq_out(freq_out), .upper_limit_flag(upper_limit_flag), .lower_limit_flag(lower_limit_flag),
    .pid_active(pid_active));

// ### tb/pidsc_field.sv
// process detector, set point source and select switch model
`timescale 1ns/10ps
module pidsc_field (
    input wire logic hclk,
    input wire logic slow,
    input wire logic [11:0] sp_tgt,
    input wire logic [11:0] pv_tgt,
    input wire logic [4:0] sel_tgt,
    output logic [11:0] setpoint_adc,
    output logic [11:0] measured_adc,
    output logic [4:0] in_term
);
    // a slow detector creeps one code a cycle, so flags must not jump ahead
    always_ff @(posedge hclk) begin
        setpoint_adc <= sp_tgt;
        in_term <= sel_tgt;
        if (!slow || measured_adc == pv_tgt) measured_adc <= pv_tgt;
        else if (measured_adc < pv_tgt) measured_adc <= measured_adc + 12'h001;
        else measured_adc <= measured_adc - 12'h001;
    end
endmodule // pidsc_field

// ### tb/pidsc_top_bench.sv
// register-level testbench of the pid speed regulator
`timescale 1ns/10ps
`include "pidsc_cfg.svh"
module pidsc_top_bench;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow, upf, lowf, pid_active;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [11:0] sp_tgt, pv_tgt, sp_adc, pv_adc;
    logic [4:0] sel_tgt, in_term;
    logic [2:0] out_term;
    logic [15:0] freq_out, base;
    int errors, cmp_count;
    localparam logic [7:0] RA [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h40, 8'h60, 8'h30};
    localparam logic [31:0] RV [11] = '{0, 32'h270F, 32'h270F, 32'h270F, 1, 0, 32'h3000110, 0, 0, 0, 0};
    pidsc_top #(.SAMPLE_CYC(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_term(in_term), .setpoint_adc(sp_adc),
        .measured_adc(pv_adc), .out_term(out_term), .freq_out(freq_out), .upper_limit_flag(upf),
        .lower_limit_flag(lowf), .pid_active(pid_active));
    pidsc_field field_u (.hclk(hclk), .slow(slow), .sp_tgt(sp_tgt), .pv_tgt(pv_tgt), .sel_tgt(sel_tgt),
        .setpoint_adc(sp_adc), .measured_adc(pv_adc), .in_term(in_term));
    // 25 MHz clock
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task results;
        if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ready is looked at mid-cycle so the edge update never races the test
    task rdy;
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                errors++;
                results();
            end
            @(negedge hclk);
        end
        @(posedge hclk);
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        q = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task settle(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask
    // flags and output terminals as one word {upper, lower, out_term}
    task flags(input logic [11:0] adc, input logic [4:0] e);
        pv_tgt <= adc;
        settle(8);
        chk({27'h0, upf, lowf, out_term}, {27'h0, e});
    endtask
    // loop direction: 2 means above base, 1 below
    task dir(input logic [7:0] act, input logic [11:0] adc, input logic [1:0] e);
        wr(8'h00, {24'h0, act});
        pv_tgt <= adc;
        settle(40);
        chk({30'h0, freq_out > base, freq_out < base}, {30'h0, e});
        chk({31'h0, pid_active}, 1);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        slow = 1'b0;
        sp_tgt = 12'h000;
        pv_tgt = 12'h000;
        sel_tgt = 5'h00;
        base = 16'h1388;
        errors = 0;
        cmp_count = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 11; i++) rd(RA[i], RV[i]);
        // plain mode passes the base frequency straight through
        wr(8'h1C, {16'h0, base});
        settle(4);
        chk({16'h0, freq_out}, {16'h0, base});
        chk({31'h0, pid_active}, 0);
        // set point from terminal, then ranges of both terminals
        sp_tgt <= 12'h800;
        wr(8'h14, 2);
        settle(6);
        rd(8'h24, 32'h03E80000);
        wr(8'h10, 11);
        wr(8'h14, 1);
        pv_tgt <= 12'h800;
        settle(6);
        rd(8'h24, 32'h03E803E8);
        wr(8'h10, 0);
        wr(8'h14, 0);
        pv_tgt <= 12'h333;
        settle(6);
        rd(8'h24, 32'h01F40000);
        wr(8'h10, 10);
        sp_tgt <= 12'hFFF;
        pv_tgt <= 12'hFFF;
        settle(6);
        rd(8'h24, 32'h03E803E8);
        wr(8'h04, 32'h1F4);
        settle(2);
        rd(8'h24, 32'h01F403E8);
        // both actions with either sign of deviation, proportional only
        wr(8'h14, 2);
        wr(8'h18, 32'h1000010);
        dir(8'h14, 12'h000, 2'h2);
        dir(8'h14, 12'hFFF, 2'h1);
        dir(8'h15, 12'h000, 2'h1);
        dir(8'h15, 12'hFFF, 2'h2);
        // every term off leaves a zero correction
        wr(8'h18, 32'h0000010);
        dir(8'h14, 12'h000, 2'h0);
        rd(8'h28, {16'h0, base});
        // limits 60 and 40 percent on three terminals of both polarities
        wr(8'h08, 32'h258);
        wr(8'h0C, 32'h190);
        wr(8'h60, 32'h0F);
        wr(8'h64, 32'h72);
        wr(8'h68, 32'h73);
        flags(12'hCCC, 5'h13);
        flags(12'h999, 5'h06);
        flags(12'h000, 5'h0C);
        flags(12'h666, 5'h06);
        flags(12'h800, 5'h06);
        // slow detector: flag waits for the value to pass the limit
        slow <= 1'b1;
        pv_tgt <= 12'hCCC;
        for (int n = 0; n < 3000 && upf !== 1'b1; n++) @(negedge hclk);
        chk({20'h0, pv_adc}, 32'h9A2);
        if (upf !== 1'b1) results();
        slow <= 1'b0;
        flags(12'hCCC, 5'h13);
        wr(8'h08, 32'h270F);
        flags(12'hCCC, 5'h06);
        wr(8'h08, 32'h258);
        // mapped select input gates regulation
        wr(8'h40, 32'h0E);
        flags(12'hCCC, 5'h06);
        sel_tgt <= 5'h01;
        flags(12'hCCC, 5'h13);
        wr(8'h00, 0);
        flags(12'hCCC, 5'h06);
        chk({16'h0, freq_out}, {16'h0, base});
        wr(8'h00, 32'h16);
        settle(4);
        chk({31'h0, pid_active}, 0);
        results();
    end
endmodule // pidsc_top_bench
